// ==== hdl/coef_bank_pkg.sv ====
// Notes on behaviour
// R01: Each coefficient is a 16-bit signed two's-complement value spanning -32768 to +32767.
// R02: The right de-emphasis denominator tap resets to 0x53 (address 51) and 0x7E (address 52).
// R03: The spatial attenuation coefficient resets to 0x7F (address 53) and 0xFF (address 54).
// R04: The left high-pass first numerator tap resets to 0x39 (address 65) and 0x55 (address 66).
// R05: The left high-pass second numerator tap resets to 0xF3 (address 67) and 0x2D (address 68).
// R06: The left high-pass denominator tap resets to 0x53 (address 69) and 0x7E (address 70).
// R07: Addresses 55 to 64 are read-only, read as zero, and the host must never write them.
// R08: The high byte gives bits 15..8, the low byte bits 7..0, and filters see each byte update.
package coef_bank_pkg;

	// ----------------------------------------
	// Address space and data widths
	// ----------------------------------------
	localparam int ADDR_W = 7;
	localparam int BYTE_W = 8;
	localparam int COEF_W = 16;
	localparam int NUM_COEF = 5;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [6:0] RIGHT_DEEMPH_DEN_HIGH = 7'h33;
	localparam logic [6:0] RIGHT_DEEMPH_DEN_LOW = 7'h34;
	localparam logic [6:0] SPATIAL_ATTEN_HIGH = 7'h35;
	localparam logic [6:0] SPATIAL_ATTEN_LOW = 7'h36;
	localparam logic [6:0] RESERVED_BLOCK_A_FIRST = 7'h37;
	localparam logic [6:0] RESERVED_BLOCK_A_LAST = 7'h40;
	localparam logic [6:0] LEFT_HPF_NUM0_HIGH = 7'h41;
	localparam logic [6:0] LEFT_HPF_NUM0_LOW = 7'h42;
	localparam logic [6:0] LEFT_HPF_NUM1_HIGH = 7'h43;
	localparam logic [6:0] LEFT_HPF_NUM1_LOW = 7'h44;
	localparam logic [6:0] LEFT_HPF_DEN_HIGH = 7'h45;
	localparam logic [6:0] LEFT_HPF_DEN_LOW = 7'h46;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RIGHT_DEEMPH_DEN_HIGH_RST = 8'h53;
	localparam logic [7:0] RIGHT_DEEMPH_DEN_LOW_RST = 8'h7E;
	localparam logic [7:0] SPATIAL_ATTEN_HIGH_RST = 8'h7F;
	localparam logic [7:0] SPATIAL_ATTEN_LOW_RST = 8'hFF;
	localparam logic [7:0] RESERVED_READ_VALUE = 8'h00;
	localparam logic [7:0] LEFT_HPF_NUM0_HIGH_RST = 8'h39;
	localparam logic [7:0] LEFT_HPF_NUM0_LOW_RST = 8'h55;
	localparam logic [7:0] LEFT_HPF_NUM1_HIGH_RST = 8'hF3;
	localparam logic [7:0] LEFT_HPF_NUM1_LOW_RST = 8'h2D;
	localparam logic [7:0] LEFT_HPF_DEN_HIGH_RST = 8'h53;
	localparam logic [7:0] LEFT_HPF_DEN_LOW_RST = 8'h7E;

	// ----------------------------------------
	// Coefficient slot tables, index order of coefOut
	// ----------------------------------------
	localparam logic [6:0] SLOT_HIGH_ADDR [NUM_COEF] = '{RIGHT_DEEMPH_DEN_HIGH,
		SPATIAL_ATTEN_HIGH, LEFT_HPF_NUM0_HIGH, LEFT_HPF_NUM1_HIGH, LEFT_HPF_DEN_HIGH};
	localparam logic [6:0] SLOT_LOW_ADDR [NUM_COEF] = '{RIGHT_DEEMPH_DEN_LOW,
		SPATIAL_ATTEN_LOW, LEFT_HPF_NUM0_LOW, LEFT_HPF_NUM1_LOW, LEFT_HPF_DEN_LOW};
	localparam logic [7:0] SLOT_HIGH_RST [NUM_COEF] = '{RIGHT_DEEMPH_DEN_HIGH_RST,
		SPATIAL_ATTEN_HIGH_RST, LEFT_HPF_NUM0_HIGH_RST, LEFT_HPF_NUM1_HIGH_RST,
		LEFT_HPF_DEN_HIGH_RST};
	localparam logic [7:0] SLOT_LOW_RST [NUM_COEF] = '{RIGHT_DEEMPH_DEN_LOW_RST,
		SPATIAL_ATTEN_LOW_RST, LEFT_HPF_NUM0_LOW_RST, LEFT_HPF_NUM1_LOW_RST,
		LEFT_HPF_DEN_LOW_RST};

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic signed [15:0] coef_type;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [6:0] addr;
		logic [7:0] wrData;
	} reg_req_type;

	typedef struct packed {
		logic rdValid;
		logic rdHit;
		logic [7:0] rdData;
		logic rsvdWrite;
	} reg_rsp_type;

endpackage

// ==== hdl/filter_coefficient_bank.sv ====
`timescale 1ns/1ps
module filter_coefficient_bank import coef_bank_pkg::*; #(
	parameter int SLOTS = NUM_COEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire reg_req_type regReq,
	output reg_rsp_type regRsp,
	output coef_type coefOut [SLOTS],
	output logic [SLOTS-1:0] coefUpdated
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (SLOTS != NUM_COEF) begin : g_bad_slots
		$error("SLOTS must equal the number of coefficient slots in the map");
	end
	if (ADDR_W != $bits(regReq.addr)) begin : g_bad_addr_w
		$error("ADDR_W must match the request address width");
	end
	if (BYTE_W * 2 != COEF_W) begin : g_bad_coef_w
		$error("A coefficient must be exactly two register bytes wide");
	end
	if (RESERVED_BLOCK_A_FIRST > RESERVED_BLOCK_A_LAST) begin : g_bad_rsvd
		$error("Reserved window bounds are reversed");
	end

	// No slot byte may alias another slot byte or the reserved window
	for (genvar m = 0; m < SLOTS; m++) begin : g_map_check
		if (SLOT_HIGH_ADDR[m] == SLOT_LOW_ADDR[m]) begin : g_same_pair
			$error("High and low byte of a slot share one address");
		end
		if ((SLOT_HIGH_ADDR[m] >= RESERVED_BLOCK_A_FIRST)
			&& (SLOT_HIGH_ADDR[m] <= RESERVED_BLOCK_A_LAST)) begin : g_high_in_rsvd
			$error("A high byte address falls in the reserved window");
		end
		if ((SLOT_LOW_ADDR[m] >= RESERVED_BLOCK_A_FIRST)
			&& (SLOT_LOW_ADDR[m] <= RESERVED_BLOCK_A_LAST)) begin : g_low_in_rsvd
			$error("A low byte address falls in the reserved window");
		end
		for (genvar n = m + 1; n < SLOTS; n++) begin : g_pair_check
			if ((SLOT_HIGH_ADDR[m] == SLOT_HIGH_ADDR[n])
				|| (SLOT_LOW_ADDR[m] == SLOT_LOW_ADDR[n])
				|| (SLOT_HIGH_ADDR[m] == SLOT_LOW_ADDR[n])
				|| (SLOT_LOW_ADDR[m] == SLOT_HIGH_ADDR[n])) begin : g_alias
				$error("Two slots share a register address");
			end
		end
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// 0x33 right de-emphasis denominator tap, high byte (slot 0)
	// 0x34 right de-emphasis denominator tap, low byte (slot 0)
	// 0x35 spatial attenuation, high byte (slot 1)
	// 0x36 spatial attenuation, low byte (slot 1)
	// 0x37 to 0x40 reserved: reads zero, writes dropped and flagged
	// 0x41 left high-pass first numerator tap, high byte (slot 2)
	// 0x42 left high-pass first numerator tap, low byte (slot 2)
	// 0x43 left high-pass second numerator tap, high byte (slot 3)
	// 0x44 left high-pass second numerator tap, low byte (slot 3)
	// 0x45 left high-pass denominator tap, high byte (slot 4)
	// 0x46 left high-pass denominator tap, low byte (slot 4)
	// Other addresses belong to neighbouring banks: ignored, read as zero
	// Each byte write lands at once; a filter may see a half-updated pair
	logic [SLOTS-1:0] hitHigh;
	logic [SLOTS-1:0] hitLow;
	logic [SLOTS-1:0] hitAny;
	logic rsvdHit;
	logic wrRsvd;
	logic [BYTE_W-1:0] rdMux;
	logic [BYTE_W-1:0] rdChain [SLOTS+1];
	logic rdHitNow;
	coef_type coef_r [SLOTS];
	logic [SLOTS-1:0] updated_r;
	reg_rsp_type rsp_r;
	reg_rsp_type rsp_nxt;

	// Reserved window never stores anything [R07]
	assign rsvdHit = (regReq.addr >= RESERVED_BLOCK_A_FIRST)
		&& (regReq.addr <= RESERVED_BLOCK_A_LAST);
	assign wrRsvd = regReq.wrEn && rsvdHit; // [R07]

	// ----------------------------------------
	// Coefficient storage, one slot per coefficient
	// ----------------------------------------
	genvar i;
	for (i = 0; i < SLOTS; i++) begin : g_slot
		logic [COEF_W-1:0] coef_nxt;

		assign hitHigh[i] = (regReq.addr == SLOT_HIGH_ADDR[i]);
		assign hitLow[i] = (regReq.addr == SLOT_LOW_ADDR[i]);
		assign hitAny[i] = hitHigh[i] || hitLow[i];

		// High byte feeds bits 15..8, low byte bits 7..0 [R08]
		assign coef_nxt = {(regReq.wrEn && hitHigh[i]) ? regReq.wrData
			: coef_r[i][COEF_W-1 -: BYTE_W],
			(regReq.wrEn && hitLow[i]) ? regReq.wrData : coef_r[i][BYTE_W-1 -: BYTE_W]};

		// Reset loads the documented byte pair of each slot [R02] [R03] [R04] [R05] [R06]
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				coef_r[i] <= {SLOT_HIGH_RST[i], SLOT_LOW_RST[i]};
				updated_r[i] <= 1'b0;
			end else begin
				coef_r[i] <= coef_nxt; // [R01]
				updated_r[i] <= regReq.wrEn && hitAny[i]; // [R08]
			end
		end

		// Signed view for the filter datapath [R01]
		assign coefOut[i] = coef_r[i];

		// Folds this slot's addressed byte into the read chain
		assign rdChain[i+1] = rdChain[i]
			| ({BYTE_W{hitHigh[i]}} & coef_r[i][COEF_W-1 -: BYTE_W])
			| ({BYTE_W{hitLow[i]}} & coef_r[i][BYTE_W-1 -: BYTE_W]);
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Chain starts at zero; reserved and foreign addresses leave it there [R07]
	assign rdChain[0] = RESERVED_READ_VALUE;
	assign rdMux = rdChain[SLOTS];

	assign rdHitNow = (|hitAny) || rsvdHit;

	// Response is registered one cycle after the request
	always_comb begin
		rsp_nxt = '0;
		rsp_nxt.rdValid = regReq.rdEn;
		rsp_nxt.rdHit = regReq.rdEn && rdHitNow;
		rsp_nxt.rdData = regReq.rdEn ? rdMux : RESERVED_READ_VALUE;
		rsp_nxt.rsvdWrite = wrRsvd; // [R07]
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	assign regRsp = rsp_r;
	assign coefUpdated = updated_r;

endmodule

// ==== dv/coef_bank_chk.sv ====
`timescale 1ns/1ps
module coef_bank_chk import coef_bank_pkg::*; #(
	parameter int SLOTS = NUM_COEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire reg_req_type regReq,
	input wire reg_rsp_type regRsp,
	input wire coef_type coefOut [SLOTS],
	input wire logic [SLOTS-1:0] coefUpdated
);
	// --
	// Request shorthands
	// --
	wire logic wr = regReq.wrEn;
	wire logic rd = regReq.rdEn;
	wire logic [6:0] ad = regReq.addr;
	wire logic [7:0] wd = regReq.wrData;
	wire logic rsv = ad inside {[RESERVED_BLOCK_A_FIRST:RESERVED_BLOCK_A_LAST]};
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Port relations
	sign_bit_a: assert property (wr && ad == SPATIAL_ATTEN_HIGH && wd[7] |=> coefOut[1] < 0)
		else $error("sign lost");
	read_back_a: assert property (rd && !wr && ad == RIGHT_DEEMPH_DEN_HIGH |=>
		regRsp.rdData == coefOut[0][15:8]) else $error("read back");
	low_byte_a: assert property (wr && ad == SPATIAL_ATTEN_LOW |=>
		coefOut[1][7:0] == $past(wd)) else $error("low byte");
	update_pulse_a: assert property (wr && ad == LEFT_HPF_NUM0_LOW |=> coefUpdated == 5'h04)
		else $error("update pulse");
	idle_hold_a: assert property (!wr |=> $stable(coefOut[3]))
		else $error("coef moved");
	high_byte_a: assert property (wr && ad == LEFT_HPF_DEN_HIGH |=>
		coefOut[4][15:8] == $past(wd)) else $error("high byte");
	rsvd_write_a: assert property (wr && rsv |=> regRsp.rsvdWrite && coefUpdated == '0)
		else $error("reserved write");
	rsvd_read_a: assert property (rd && rsv |=> regRsp.rdHit && regRsp.rdData == 8'h00)
		else $error("reserved read");
	cover property (regRsp.rsvdWrite);
	cover property (coefUpdated[4]);
	cover property (regRsp.rdValid && regRsp.rdHit);
endmodule
bind filter_coefficient_bank coef_bank_chk #(.SLOTS(SLOTS)) u_coef_bank_chk (.clk(clk),
	.nrst(nrst), .regReq(regReq), .regRsp(regRsp), .coefOut(coefOut), .coefUpdated(coefUpdated));

// ==== dv/coef_host.sv ====
`timescale 1ns/1ps
module coef_host import coef_bank_pkg::*; (
	input wire logic clk,
	output reg_req_type regReq
);
	// --
	// Host request driver
	// --
	initial regReq = '0;
	// Reserved places are written only where a refusal is wanted
	task automatic put(input logic w, r, input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		regReq <= '{w, r, a, d};
	endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
	import coef_bank_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	reg_req_type regReq;
	reg_rsp_type regRsp;
	coef_type coefOut [NUM_COEF];
	logic [NUM_COEF-1:0] coefUpdated;
	int miscompares = 0;
	int n_checks = 0;
	localparam logic [15:0] RST [NUM_COEF] = '{16'h537E, 16'h7FFF, 16'h3955, 16'hF32D, 16'h537E};
	// --
	// Clock, partner and block
	// --
	always #2.5 clk = ~clk;
	coef_host u_coef_host (.clk(clk), .regReq(regReq));
	filter_coefficient_bank #(.SLOTS(NUM_COEF)) u_filter_coefficient_bank (.clk(clk), .nrst(nrst),
		.regReq(regReq), .regRsp(regRsp), .coefOut(coefOut), .coefUpdated(coefUpdated));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			$display("FAIL %s exp %h got %h", n, e, s);
			miscompares++;
		end
	endtask
	// One request, back just after the answering edge
	task automatic req(input logic w, r, input logic [6:0] a, input logic [7:0] d);
		u_coef_host.put(w, r, a, d);
		u_coef_host.put(1'b0, 1'b0, 7'h00, 8'h00);
		#1;
	endtask
	// Read one byte and judge data, valid and hit flags
	task automatic rd_byte(input logic [6:0] a, input logic [7:0] e, input logic h);
		req(1'b0, 1'b1, a, 8'h00);
		chk("rdData", 16'(regRsp.rdData), 16'(e));
		chk("rdValid", 16'(regRsp.rdValid), 16'h0001);
		chk("rdHit", 16'(regRsp.rdHit), 16'(h));
	endtask
	task automatic check_reset();
		for (int i = 0; i < NUM_COEF; i++) begin
			chk("coefOut", coefOut[i], RST[i]);
			req(1'b0, 1'b1, SLOT_HIGH_ADDR[i], 8'h00);
			chk("rdData", 16'(regRsp.rdData), {8'h00, RST[i][15:8]});
			req(1'b0, 1'b1, SLOT_LOW_ADDR[i], 8'h00);
			chk("rdDataLow", 16'(regRsp.rdData), {8'h00, RST[i][7:0]});
		end
	endtask
	task automatic check_writes();
		req(1'b1, 1'b0, LEFT_HPF_DEN_HIGH, 8'hC4);
		chk("coefOut4", coefOut[4], 16'hC47E);
		chk("coefUpdated", 16'(coefUpdated), 16'h0010);
		req(1'b1, 1'b0, LEFT_HPF_DEN_LOW, 8'h01);
		chk("coefOut4", coefOut[4], 16'hC401);
		req(1'b1, 1'b0, LEFT_HPF_NUM0_LOW, 8'h5A);
		chk("coefOut2", coefOut[2], 16'h395A);
		req(1'b1, 1'b0, SPATIAL_ATTEN_HIGH, 8'h80);
		chk("coefOut1", coefOut[1], 16'h80FF);
		req(1'b0, 1'b1, LEFT_HPF_DEN_HIGH, 8'h00);
		chk("rdData", 16'(regRsp.rdData), 16'h00C4);
	endtask
	task automatic check_reserved();
		for (int a = RESERVED_BLOCK_A_FIRST; a <= RESERVED_BLOCK_A_LAST; a++) begin
			req(1'b1, 1'b0, 7'(a), 8'hA5);
			chk("rsvdWrite", 16'(regRsp.rsvdWrite), 16'h0001);
			req(1'b0, 1'b1, 7'(a), 8'h00);
			chk("rsvdRead", 16'(regRsp.rdData), 16'h0000);
			chk("rsvdHit", 16'(regRsp.rdHit), 16'h0001);
		end
		chk("coefOut4", coefOut[4], 16'hC401);
	endtask
	task automatic check_slots();
		req(1'b1, 1'b0, RIGHT_DEEMPH_DEN_HIGH, 8'h12);
		chk("coefOut0", coefOut[0], 16'h127E);
		chk("coefUpdated", 16'(coefUpdated), 16'h0001);
		@(posedge clk);
		#1;
		chk("coefUpdated", 16'(coefUpdated), 16'h0000);
		req(1'b1, 1'b0, RIGHT_DEEMPH_DEN_LOW, 8'h34);
		chk("coefOut0", coefOut[0], 16'h1234);
		req(1'b1, 1'b0, SPATIAL_ATTEN_LOW, 8'h00);
		chk("coefOut1", coefOut[1], 16'h8000);
		chk("coefUpdated", 16'(coefUpdated), 16'h0002);
		req(1'b1, 1'b0, LEFT_HPF_NUM1_HIGH, 8'h0C);
		chk("coefOut3", coefOut[3], 16'h0C2D);
		chk("coefUpdated", 16'(coefUpdated), 16'h0008);
		rd_byte(LEFT_HPF_NUM1_HIGH, 8'h0C, 1'b1);
	endtask
	task automatic check_foreign();
		req(1'b1, 1'b0, 7'h32, 8'h5A);
		chk("coefUpdated", 16'(coefUpdated), 16'h0000);
		chk("rsvdWrite", 16'(regRsp.rsvdWrite), 16'h0000);
		rd_byte(7'h32, 8'h00, 1'b0);
		rd_byte(7'h47, 8'h00, 1'b0);
		// Read and write together return the old byte
		req(1'b1, 1'b1, LEFT_HPF_NUM0_HIGH, 8'hA1);
		chk("rdData", 16'(regRsp.rdData), 16'h0039);
		chk("coefOut2", coefOut[2], 16'hA15A);
		rd_byte(LEFT_HPF_NUM0_HIGH, 8'hA1, 1'b1);
	endtask
	task automatic check_midrun_reset();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		check_reset();
	endtask
	task automatic close_out();
		if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		check_reset();
		check_writes();
		check_reserved();
		check_slots();
		check_foreign();
		check_midrun_reset();
		close_out();
	end
	// Hang guard
	initial begin
		#100000;
		miscompares++;
		close_out();
	end
endmodule
